// ---- test/eclc_eeprom_model.sv ----
/* eclc_eeprom_model: eeprom reader behind the smbus engine port.
   assumes eng_start is a one-cycle pulse; answers lat+1 cycles after it. */
module eclc_eeprom_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic eng_start,
	input wire logic fail_next,
	input wire logic [7:0] lat,
	output logic eng_clock_low,
	output logic eng_finish_ok,
	output logic eng_finish_fail
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt = 0; // cycles left in the read
	// ========================================
	// one read per start; clock pulled low on alternate cycles while busy
	always @(posedge clk) begin
		eng_finish_ok <= 1'b0;
		eng_finish_fail <= 1'b0;
		if (rst) begin
			cnt <= 0;
			eng_clock_low <= 1'b0;
		end else if (eng_start) begin
			cnt <= lat + 1;
		end else if (cnt > 0) begin
			cnt <= cnt - 1;
			eng_clock_low <= ~eng_clock_low & (cnt > 1);
			if (cnt == 1) begin
				eng_finish_ok <= !fail_next;
				eng_finish_fail <= fail_next;
			end
		end
	end
endmodule // eclc_eeprom_model

// ---- test/eclc_top_props.sv ----
/* eclc_props: port checker for eclc_top, bound at the foot.
   assumes one clock domain and a synchronous active-high rst. */
module eclc_props (
	input wire logic clk,
	input wire logic rst,
	input wire logic load_request_n,
	input wire logic done_n_o,
	input wire logic done_n_oe,
	input wire logic cal_clk_in,
	input wire logic cal_clk_out,
	input wire logic smbus_clock_pin_o,
	input wire logic smbus_clock_pin_oe,
	input wire logic eng_clock_low,
	input wire logic eng_finish_ok,
	input wire logic eng_finish_fail,
	input wire logic eng_start,
	input wire logic eng_reset,
	input wire logic [eclc_pkg::ECLC_SMB_ADDR_W-1:0] smbus_address,
	input wire eclc_pkg::eclc_role_t bus_role
);
	timeunit 1ns;
	timeprecision 100ps;
	import eclc_pkg::*;
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// ========================================
	// pins, engine handshake and straps
	property p_cal; !$past(rst) |-> cal_clk_out == $past(cal_clk_in); endproperty
	a_cal: assert property (p_cal) else $error("cal clock copy wrong");
	property p_start; eng_start |-> bus_role == ECLC_ROLE_MASTER && !$past(eng_start); endproperty
	a_start: assert property (p_start) else $error("start outside master");
	property p_done; $fell(done_n_o) && bus_role == ECLC_ROLE_MASTER |-> $past(eng_finish_ok, 2);
	endproperty
	a_done: assert property (p_done) else $error("done without good load");
	property p_fail; eng_finish_fail && done_n_o |=> done_n_o [*2]; endproperty
	a_fail: assert property (p_fail) else $error("done after failed load");
	property p_son; bus_role == ECLC_ROLE_SLAVE && !load_request_n |=> done_n_oe && !done_n_o;
	endproperty
	a_son: assert property (p_son) else $error("slave done not driven low");
	property p_soff; bus_role == ECLC_ROLE_SLAVE && load_request_n |=> !done_n_oe; endproperty
	a_soff: assert property (p_soff) else $error("slave done not released");
	property p_erst; bus_role == ECLC_ROLE_SLAVE |=> eng_reset == !$past(load_request_n);
	endproperty
	a_erst: assert property (p_erst) else $error("engine reset wrong");
	// the clock pin only pulls low, and only for a master
	property p_scl; !$past(rst, 2) |-> !smbus_clock_pin_o
		&& smbus_clock_pin_oe == ($past(eng_clock_low) && bus_role == ECLC_ROLE_MASTER);
	endproperty
	a_scl: assert property (p_scl) else $error("clock pin drive wrong");
	property p_addr; !$past(rst, 3) |-> $stable(smbus_address); endproperty
	a_addr: assert property (p_addr) else $error("address moved after capture");
endmodule // eclc_props

bind eclc_top eclc_props u_props (.clk(clk), .rst(rst), .load_request_n(load_request_n),
	.done_n_o(done_n_o), .done_n_oe(done_n_oe), .cal_clk_in(cal_clk_in),
	.cal_clk_out(cal_clk_out), .smbus_clock_pin_o(smbus_clock_pin_o),
	.smbus_clock_pin_oe(smbus_clock_pin_oe), .eng_clock_low(eng_clock_low),
	.eng_finish_ok(eng_finish_ok), .eng_finish_fail(eng_finish_fail), .eng_start(eng_start),
	.eng_reset(eng_reset), .smbus_address(smbus_address), .bus_role(bus_role));

// ---- test/testbench.sv ----
/* testbench: eclc_top over apb and its pins, with the eeprom model.
   assumes pull-ups on done, request and clock pins; 200 mhz clk. */
module testbench;
	timeunit 1ns;
	timeprecision 100ps;
	import eclc_pkg::*;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, load_request_n = 1;
	logic cal_clk_in = 0, fail_next = 0, pready, pslverr, done_n_o, done_n_oe, cal_clk_out;
	logic smbus_clock_pin_o, smbus_clock_pin_oe, eng_clock_low, eng_finish_ok, eng_finish_fail;
	logic eng_start, eng_reset, smbus_clock_pin_i, done_w;
	logic [7:0] paddr = 0, lat = 2;
	logic [31:0] pwdata = 0, prdata;
	logic [6:0] smbus_address;
	eclc_level_t address_strap0 = ECLC_LVL_FLOAT, address_strap1 = ECLC_LVL_FLOAT;
	eclc_level_t bus_role_select = ECLC_LVL_FLOAT;
	eclc_role_t bus_role;
	int n_errors = 0, n_checks = 0, cyc = 0, n_starts = 0, exp_addr, exp_role;
	// open-drain wires with board pull-ups
	assign smbus_clock_pin_i = smbus_clock_pin_oe ? smbus_clock_pin_o : 1'b1;
	assign done_w = done_n_oe ? done_n_o : 1'b1;
	eclc_top dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.address_strap0(address_strap0), .address_strap1(address_strap1),
		.bus_role_select(bus_role_select), .load_request_n(load_request_n),
		.done_n_o(done_n_o), .done_n_oe(done_n_oe), .cal_clk_in(cal_clk_in),
		.cal_clk_out(cal_clk_out), .smbus_clock_pin_i(smbus_clock_pin_i),
		.smbus_clock_pin_o(smbus_clock_pin_o), .smbus_clock_pin_oe(smbus_clock_pin_oe),
		.eng_clock_low(eng_clock_low), .eng_finish_ok(eng_finish_ok),
		.eng_finish_fail(eng_finish_fail), .eng_start(eng_start), .eng_reset(eng_reset),
		.smbus_address(smbus_address), .bus_role(bus_role));
	eclc_eeprom_model eeprom (.clk(clk), .rst(rst), .eng_start(eng_start),
		.fail_next(fail_next), .lat(lat), .eng_clock_low(eng_clock_low),
		.eng_finish_ok(eng_finish_ok), .eng_finish_fail(eng_finish_fail));
	// ========================================
	// clock, 25 mhz calibration clock, start counter, hang limit
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 3) cal_clk_in <= ~cal_clk_in;
		if (eng_start === 1'b1 && !rst) n_starts <= n_starts + 1;
		if (cyc == 3000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// one apb transfer; the leading edge keeps back-to-back calls apart
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// done pin settles two edges after the finish pulse
	task automatic wait_fin;
		while (eng_finish_ok !== 1'b1 && eng_finish_fail !== 1'b1) @(posedge clk);
		repeat (3) @(posedge clk);
	endtask
	initial begin
		logic [31:0] rd;
		logic er;
		void'($urandom(32'h7B1958F0));
		for (int r = 0; r < 4; r++) begin
			bus_role_select <= eclc_level_t'(r);
			address_strap0 <= eclc_level_t'($urandom % 4);
			address_strap1 <= eclc_level_t'($urandom % 4);
			load_request_n <= 1;
			rst <= 1;
			repeat (20) @(posedge clk);
			rst <= 0;
			n_starts = 0;
			exp_addr = 7'h50 | {address_strap1, address_strap0};
			exp_role = (r == 2) ? 1 : (r == 3) ? 2 : 0;
			repeat (3) @(posedge clk);
			address_strap0 <= eclc_level_t'(~address_strap0); // too late to count
			apb(0, 8'h04, 0, rd, er);
			chk(rd[14:8], exp_addr);
			chk(smbus_address, exp_addr);
			chk({rd[4:2], bus_role}, {1'b1, exp_role[1:0], exp_role[1:0]});
			apb(0, 8'h00, 0, rd, er);
			chk({done_w, rd}, 33'h1_0000_0002);
			if (r == 2) begin
				fail_next <= 1;
				lat <= 8'($urandom % 8 + 2);
				load_request_n <= 0;
				wait_fin();
				apb(0, 8'h04, 0, rd, er);
				chk({done_w, rd[1:0]}, 3'b110);
				load_request_n <= 1;
				fail_next <= 0;
				repeat (3) @(posedge clk);
				load_request_n <= 0;
				wait_fin();
				chk({done_w, 4'(n_starts)}, 5'h02);
				load_request_n <= 1;
				repeat (2) @(posedge clk);
				load_request_n <= 0;
				repeat (20) @(posedge clk);
				chk({done_w, 4'(n_starts)}, 5'h02);
				apb(1, 8'h00, 32'h0000_0003, rd, er);
				repeat (3) @(posedge clk);
				chk(done_w, 1);
				wait_fin();
				chk({done_w, 4'(n_starts)}, 5'h03);
			end else begin
				load_request_n <= 0;
				repeat (4) @(posedge clk);
				apb(1, 8'h00, 0, rd, er);
				apb(0, 8'h00, 0, rd, er);
				if (r == 3) chk({done_w, done_n_oe, eng_reset, rd}, 35'h3_0000_0002);
				else chk({done_w, done_n_oe, 4'(n_starts), rd[1:0]}, 8'h80);
				load_request_n <= 1;
				repeat (3) @(posedge clk);
				if (r == 3) chk({done_w, done_n_oe, eng_reset}, 3'b100);
			end
		end
		apb(0, 8'h08, 0, rd, er);
		chk({er, rd}, 33'h1_0000_0000);
		end_sim();
	end
endmodule // testbench

// ---- verilog/eclc_load_seq.sv ----
/*
 * eeprom load sequencer: starts one load per request seen in idle, tracks the result.
 * assumes the eeprom engine answers every start with one finish pulse.
 */
module eclc_load_seq (
	input wire logic clk,
	input wire logic rst,
	eclc_seq_if.seq sq
);
	import eclc_pkg::*;

	// ==========================================================
	// state machine
	// ==========================================================
	// a failed load waits for the request to be released and
	// raised again, so a stuck-low pin does not hammer the eeprom
	always_ff @(posedge clk) begin
		if (rst || !sq.run_master) begin
			sq.state <= ECLC_ST_IDLE;
		end else begin
			unique case (sq.state)
				ECLC_ST_IDLE: begin
					if (sq.request) begin
						sq.state <= ECLC_ST_LOAD;
					end
				end
				ECLC_ST_LOAD: begin
					if (sq.finish_ok) begin
						sq.state <= ECLC_ST_DONE;
					end else if (sq.finish_fail) begin
						sq.state <= ECLC_ST_FAIL;
					end
				end
				ECLC_ST_DONE: begin
					// request may stay low here without effect
					if (sq.reload) begin
						sq.state <= ECLC_ST_LOAD;
					end
				end
				ECLC_ST_FAIL: begin
					if (sq.reload) begin
						sq.state <= ECLC_ST_LOAD;
					end else if (!sq.request) begin
						sq.state <= ECLC_ST_IDLE;
					end
				end
			endcase
		end
	end

	// start pulse on every entry to the load state
	always_ff @(posedge clk) begin
		if (rst || !sq.run_master) begin
			sq.start <= 1'b0;
		end else begin
			sq.start <= ((sq.state == ECLC_ST_IDLE) && sq.request) ||
				((sq.state == ECLC_ST_DONE || sq.state == ECLC_ST_FAIL) && sq.reload);
		end
	end

endmodule // eclc_load_seq

// ---- verilog/eclc_pkg.sv ----
/*
 * constants, types and helpers shared by the configuration load control block.
 * assumes a single 200 mhz clock and an apb register port with 32-bit data.
 */
// Function
// - sample two address straps once, 16 addresses
// - decode each strap into four levels
// - float selects master, high selects slave
// - master: done high until successful load
// - slave: done high-z until request low
// - done chains request reset to next device
// - master: low request starts eeprom read
// - slave: low request resets smbus and registers
// - forward buffered copy of calibration clock
// - smbus clock pin drives only as master
package eclc_pkg;

	// ==========================================================
	// strap levels, as coded by the four-level pad comparator
	// ==========================================================
	typedef enum logic [1:0] {
		ECLC_LVL_STRONG_LOW = 2'h0, // 1k to ground
		ECLC_LVL_WEAK_LOW = 2'h1, // 10k to ground
		ECLC_LVL_FLOAT = 2'h2, // left open
		ECLC_LVL_STRONG_HIGH = 2'h3 // 1k to supply
	} eclc_level_t;

	// bus role derived from the role strap
	typedef enum logic [1:0] {
		ECLC_ROLE_NONE = 2'h0, // reserved strap level, no mode
		ECLC_ROLE_MASTER = 2'h1,
		ECLC_ROLE_SLAVE = 2'h2
	} eclc_role_t;

	// load sequencer states, gray along idle -> load -> done
	typedef enum logic [1:0] {
		ECLC_ST_IDLE = 2'h0,
		ECLC_ST_LOAD = 2'h1,
		ECLC_ST_DONE = 2'h3,
		ECLC_ST_FAIL = 2'h2
	} eclc_state_t;

	// ==========================================================
	// register map
	// ==========================================================
	localparam int ECLC_ADDR_W = 8;
	localparam logic [ECLC_ADDR_W-1:0] ECLC_OFS_CTRL = 8'h00;
	localparam logic [ECLC_ADDR_W-1:0] ECLC_OFS_STATUS = 8'h04;
	localparam int ECLC_CTRL_RELOAD = 0; // write one: rerun the load
	localparam int ECLC_CTRL_LOAD_EN = 1; // gates master load start
	localparam logic ECLC_CTRL_LOAD_EN_RST = 1'h1;
	localparam int ECLC_ST_STATE_LSB = 0; // [1:0] sequencer state
	localparam int ECLC_ST_ROLE_LSB = 2; // [3:2] bus role
	localparam int ECLC_ST_SAMPLED = 4; // straps captured
	localparam int ECLC_ST_REQ = 5; // load request level
	localparam int ECLC_ST_SCL_IN = 6; // smbus clock pin level
	localparam int ECLC_ST_ADDR_LSB = 8; // [14:8] smbus address
	localparam int ECLC_SMB_ADDR_W = 7;
	localparam int ECLC_STRAP_IDX_W = 4;

	// ==========================================================
	// helpers
	// ==========================================================
	// role from strap level: only float and strong high are modes
	function automatic eclc_role_t eclc_role(input eclc_level_t lvl);
		eclc_role_t r;
		r = ECLC_ROLE_NONE;
		if (lvl == ECLC_LVL_FLOAT) begin
			r = ECLC_ROLE_MASTER;
		end else if (lvl == ECLC_LVL_STRONG_HIGH) begin
			r = ECLC_ROLE_SLAVE;
		end
		return r;
	endfunction

endpackage : eclc_pkg

// ---- verilog/eclc_seq_if.sv ----
/*
 * carrier between the top and the load sequencer.
 * assumes both ends share clk and rst of the top.
 */
interface eclc_seq_if;
	import eclc_pkg::*;
	logic run_master; // master role and loading allowed
	logic request; // load request asserted (pin low)
	logic reload; // software rerun pulse
	logic finish_ok; // engine reports successful load
	logic finish_fail; // engine reports failed load
	logic start; // start pulse to the engine
	eclc_state_t state; // sequencer state
	modport ctl (output run_master, request, reload, finish_ok, finish_fail,
		input start, state);
	modport seq (input run_master, request, reload, finish_ok, finish_fail,
		output start, state);
endinterface : eclc_seq_if

// ---- verilog/eclc_top.sv ----
/*
 * configuration load control: straps, bus role, load request and done
 * pins, calibration clock forward, apb status and control.
 * assumes pad comparators deliver each four-level strap as a 2-bit code
 * and the board pull-up makes an open request pin read high.
 */
module eclc_top #(
	parameter logic [eclc_pkg::ECLC_SMB_ADDR_W-1:0] SMB_ADDR_BASE = 7'h50 // low 4 bits zero
) (
	input wire logic clk,
	input wire logic rst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [eclc_pkg::ECLC_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// straps and pins
	input wire eclc_pkg::eclc_level_t address_strap0,
	input wire eclc_pkg::eclc_level_t address_strap1,
	input wire eclc_pkg::eclc_level_t bus_role_select,
	input wire logic load_request_n,
	output logic done_n_o,
	output logic done_n_oe,
	input wire logic cal_clk_in,
	output logic cal_clk_out,
	input wire logic smbus_clock_pin_i,
	output logic smbus_clock_pin_o,
	output logic smbus_clock_pin_oe,
	// eeprom / smbus engine side
	input wire logic eng_clock_low,
	input wire logic eng_finish_ok,
	input wire logic eng_finish_fail,
	output logic eng_start,
	output logic eng_reset,
	output logic [eclc_pkg::ECLC_SMB_ADDR_W-1:0] smbus_address,
	output eclc_pkg::eclc_role_t bus_role
);
	import eclc_pkg::*;

	// elaboration check: the strap bits are ored into the low bits,
	// so a base with any of them set would alias addresses
	if (SMB_ADDR_BASE[ECLC_STRAP_IDX_W-1:0] != '0) begin : g_bad_base
		$error("SMB_ADDR_BASE low bits must be zero");
	end

	// ==========================================================
	// strap capture
	// ==========================================================
	logic sampled; // straps captured once after reset
	logic [ECLC_STRAP_IDX_W-1:0] strap_idx; // combined address straps
	logic request; // load request asserted

	// capture at the first edge after reset release, then freeze
	always_ff @(posedge clk) begin
		if (rst) begin
			sampled <= 1'b0;
			strap_idx <= '0;
			bus_role <= ECLC_ROLE_NONE;
		end else if (!sampled) begin
			sampled <= 1'b1;
			strap_idx <= {address_strap1, address_strap0};
			bus_role <= eclc_role(bus_role_select);
		end
	end

	// 16 addresses: base plus the four strap bits
	always_ff @(posedge clk) begin
		if (rst) begin
			smbus_address <= '0;
		end else begin
			smbus_address <= SMB_ADDR_BASE | {3'h0, strap_idx};
		end
	end

	// open pin is pulled high, so only a driven low asserts
	assign request = !load_request_n;

	// ==========================================================
	// control register and slave-mode reset
	// ==========================================================
	logic slave_hold; // slave role with request low
	logic ctrl_load_en; // software load gate
	logic ctrl_reload; // one-cycle rerun pulse
	logic wr_ctrl; // apb write to control in access phase

	assign slave_hold = (bus_role == ECLC_ROLE_SLAVE) && request;
	assign wr_ctrl = psel && penable && pwrite && (paddr == ECLC_OFS_CTRL);

	// registers are held in reset while the slave request is low
	always_ff @(posedge clk) begin
		if (rst || slave_hold) begin
			ctrl_load_en <= ECLC_CTRL_LOAD_EN_RST;
			ctrl_reload <= 1'b0;
		end else begin
			ctrl_reload <= wr_ctrl && pwdata[ECLC_CTRL_RELOAD];
			if (wr_ctrl) begin
				ctrl_load_en <= pwdata[ECLC_CTRL_LOAD_EN];
			end
		end
	end

	// smbus state machine reset follows the slave hold
	always_ff @(posedge clk) begin
		if (rst) begin
			eng_reset <= 1'b1;
		end else begin
			eng_reset <= slave_hold;
		end
	end

	// ==========================================================
	// load sequencer
	// ==========================================================
	eclc_seq_if sq ();

	assign sq.run_master = sampled && (bus_role == ECLC_ROLE_MASTER) && ctrl_load_en;
	assign sq.request = request;
	assign sq.reload = ctrl_reload;
	assign sq.finish_ok = eng_finish_ok;
	assign sq.finish_fail = eng_finish_fail;

	eclc_load_seq u_seq (
		.clk(clk),
		.rst(rst),
		.sq(sq)
	);

	// start pulse is already a flop output inside the sequencer
	always_ff @(posedge clk) begin
		if (rst) begin
			eng_start <= 1'b0;
		end else begin
			eng_start <= sq.start;
		end
	end

	// ==========================================================
	// done pin
	// ==========================================================
	// master drives always, low only after success; slave floats
	// and pulls low while its request is low, so a chain passes
	// the reset on and also releases it in turn
	always_ff @(posedge clk) begin
		if (rst) begin
			done_n_o <= 1'b1;
			done_n_oe <= 1'b0;
		end else if (bus_role == ECLC_ROLE_MASTER) begin
			done_n_oe <= 1'b1;
			done_n_o <= !(sq.state == ECLC_ST_DONE);
		end else if (bus_role == ECLC_ROLE_SLAVE) begin
			done_n_oe <= request;
			done_n_o <= 1'b0;
		end else begin
			done_n_oe <= 1'b0; // reserved role: pin left floating
			done_n_o <= 1'b1;
		end
	end

	// ==========================================================
	// smbus clock pin and calibration clock
	// ==========================================================
	// open drain: only ever pulls low, and only as master
	always_ff @(posedge clk) begin
		if (rst) begin
			smbus_clock_pin_o <= 1'b0;
			smbus_clock_pin_oe <= 1'b0;
		end else begin
			smbus_clock_pin_o <= 1'b0;
			smbus_clock_pin_oe <= (bus_role == ECLC_ROLE_MASTER) && eng_clock_low;
		end
	end

	// retimed copy; 200 mhz sampling adds up to 5 ns of jitter,
	// acceptable since the calibration clock has no jitter budget
	always_ff @(posedge clk) begin
		if (rst) begin
			cal_clk_out <= 1'b0;
		end else begin
			cal_clk_out <= cal_clk_in;
		end
	end

	// ==========================================================
	// apb slave: zero wait states, data prepared in setup phase
	// ==========================================================
	logic [31:0] next_prdata; // read mux
	logic next_err; // unmapped address

	always_comb begin
		next_prdata = '0;
		next_err = 1'b0;
		unique case (paddr)
			ECLC_OFS_CTRL: begin
				next_prdata[ECLC_CTRL_LOAD_EN] = ctrl_load_en;
			end
			ECLC_OFS_STATUS: begin
				next_prdata[ECLC_ST_STATE_LSB +: 2] = sq.state;
				next_prdata[ECLC_ST_ROLE_LSB +: 2] = bus_role;
				next_prdata[ECLC_ST_SAMPLED] = sampled;
				next_prdata[ECLC_ST_REQ] = request;
				next_prdata[ECLC_ST_SCL_IN] = smbus_clock_pin_i;
				next_prdata[ECLC_ST_ADDR_LSB +: ECLC_SMB_ADDR_W] = smbus_address;
			end
			default: begin
				next_err = 1'b1;
			end
		endcase
	end

	// read data and error settle in setup, stand through access
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= '0;
			pslverr <= 1'b0;
			pready <= 1'b0;
		end else begin
			pready <= 1'b1;
			if (psel && !penable) begin
				prdata <= pwrite ? 32'h0000_0000 : next_prdata;
				pslverr <= next_err;
			end
		end
	end

endmodule // eclc_top
